// ==== inc/ext_bus_pkg.sv ====
// Purpose: Shared constants and types for the external bus ready control
// Assumes: One system clock at 40 MHz, bus reference clock made by a divider
// Notes:   All timing counts derive from times given in nanoseconds
package ext_bus_pkg;

  // System clock period and bus reference clock period
  localparam int unsigned SYS_PERIOD_NS = 25;
  localparam int unsigned BUS_PERIOD_NS = 200;
  // System clocks per bus reference clock period (rounded down, min 1)
  localparam int unsigned BUS_DIV_RAW   = BUS_PERIOD_NS / SYS_PERIOD_NS;
  localparam int unsigned BUS_DIV       = (BUS_DIV_RAW < 1) ? 1 : BUS_DIV_RAW;
  localparam logic [3:0]  DIV_LAST      = 4'(BUS_DIV - 1);
  localparam logic [3:0]  DIV_HALF      = 4'(BUS_DIV / 2 - 1);

  // Field widths of the bus
  localparam int unsigned ADDR_W = 24;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned CNT_W  = 4;
  localparam int unsigned WAIT_W = 8;

  // Idle, start and step values of pins and counters
  localparam logic [ADDR_W-1:0] ADDR_IDLE = 24'h000000;
  localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0]  CNT_ONE   = 4'h1;
  localparam logic [WAIT_W-1:0] WAIT_ZERO = 8'h00;
  localparam logic [WAIT_W-1:0] WAIT_ONE  = 8'h01;

  // Bus cycle phases
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_ADDR,
    PH_CMD,
    PH_END
  } phase_t;

endpackage

// ==== inc/ready_if.sv ====
`timescale 1ns/1ps
// Purpose: Link between the cycle sequencer and the ready sampler
// Assumes: Both ends run on ref_clk
// Notes:   Sequencer opens the sample window, sampler answers readyOk
interface ready_if;
  logic tick;        // Rising edge moment of the bus reference clock
  logic sampleEn;    // Valid sample point window of a ready cycle
  logic asyncMode;   // Extra synchronizer stage selected
  logic activeHigh;  // High level on the pin means ready
  logic readyOk;     // Ready seen at this sample point

  modport seq (output tick, output sampleEn, output asyncMode,
               output activeHigh, input readyOk);
  modport smp (input tick, input sampleEn, input asyncMode,
               input activeHigh, output readyOk);
endinterface

// ==== core/ready_sampler.sv ====
`timescale 1ns/1ps
// Purpose: Synchronise the ready pin and apply polarity and async stage
// Assumes: readyPin is asynchronous to ref_clk
// Notes:   Async stage is cleared outside the window to force one wait
module ready_sampler (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic readyPin,
  ready_if.smp      rdy
);
  import ext_bus_pkg::*;

  // All sampler state in one register
  typedef struct packed {
    logic meta;   // First synchroniser flop, read only by sync
    logic sync;   // Second synchroniser flop
    logic stage;  // Added bus-clock synchronisation stage
  } smp_t;

  smp_t state_r;   // Registered state
  smp_t state_nxt; // Next state
  logic levelOk;   // Pin level after polarity selection

  // Polarity selection on the synchronised pin
  always_comb begin
    levelOk = rdy.activeHigh ? state_r.sync : ~state_r.sync;
  end

  // Next state; the stage loads levelOk at window sample points and clears at other ticks
  always_comb begin
    state_nxt      = state_r;
    state_nxt.meta = readyPin;
    state_nxt.sync = state_r.meta;
    if (rdy.tick) begin
      state_nxt.stage = rdy.sampleEn ? levelOk : 1'b0;
    end
  end

  // Sync mode reads the synchronised level levelOk, async mode reads the stage
  always_comb begin
    rdy.readyOk = rdy.asyncMode ? state_r.stage : levelOk;
  end

  // State register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  a_sync_polarity: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rdy.tick && !rdy.asyncMode |->
      rdy.readyOk == (state_r.sync == rdy.activeHigh))
    else $error("sync ready does not follow pin and polarity");

  a_async_stage: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rdy.tick && rdy.asyncMode && rdy.sampleEn |=>
      rdy.readyOk == $past(levelOk))
    else $error("async ready is not one sample late");

endmodule // ready_sampler

// ==== core/ext_bus_ready_wait_control.sv ====
`timescale 1ns/1ps
// Purpose: External bus cycle sequencer with ready-controlled wait states
// Assumes: Requests come from logic on ref_clk; pins are asynchronous
// Notes:   Phases advance on rising edges of the bus reference clock
module ext_bus_ready_wait_control (
  input  wire logic                         ref_clk,
  input  wire logic                         rst_n,
  input  wire logic                         reqValid,
  input  wire logic                         reqWrite,
  input  wire logic [ext_bus_pkg::ADDR_W-1:0] reqAddr,
  input  wire logic [ext_bus_pkg::DATA_W-1:0] reqWdata,
  input  wire logic                         reqUpper,
  input  wire logic                         cfgReadyCtl,
  input  wire logic                         cfgAsync,
  input  wire logic                         cfgActiveHigh,
  input  wire logic [ext_bus_pkg::CNT_W-1:0]  cfgCmdTicks,
  input  wire logic                         readyPin,
  input  wire logic [ext_bus_pkg::DATA_W-1:0] dataIn,
  output logic                              reqReady,
  output logic                              doneValid,
  output logic [ext_bus_pkg::DATA_W-1:0]      rdData,
  output logic [ext_bus_pkg::WAIT_W-1:0]      waitCount,
  output logic [ext_bus_pkg::ADDR_W-1:0]      addrOut,
  output logic                              rdStrobeN,
  output logic                              wrStrobeN,
  output logic                              upperByteSelectN,
  output logic [ext_bus_pkg::DATA_W-1:0]      dataOut,
  output logic                              dataOe,
  output logic                              busReferenceClock
);
  import ext_bus_pkg::*;

  // All sequencer state in one register
  typedef struct packed {
    phase_t            phase;     // Bus cycle phase
    logic [3:0]        divCnt;    // Reference clock divider
    logic              busClk;    // Reference clock level
    logic [CNT_W-1:0]  cmdCnt;    // Command ticks elapsed
    logic [CNT_W-1:0]  cmdTicks;  // Programmed command ticks
    logic              write;     // Cycle direction
    logic              readyCtl;  // Cycle governed by ready
    logic              async;     // Async ready for this cycle
    logic              actHigh;   // Ready polarity for this cycle
    logic [WAIT_W-1:0] waits;     // Wait states inserted
    logic [ADDR_W-1:0] addr;      // Address pins
    logic              rdN;       // Read strobe
    logic              wrN;       // Write strobe
    logic              upperN;    // Upper byte select
    logic [DATA_W-1:0] wdata;     // Write data pins
    logic              oe;        // Data pins driven
    logic [DATA_W-1:0] dMeta;     // Read data first sync flop
    logic [DATA_W-1:0] dSync;     // Read data second sync flop
    logic [DATA_W-1:0] rdata;     // Captured read data
    logic              done;      // End of cycle pulse
    logic              idle;      // Ready for a request
  } seq_t;

  seq_t    state_r;   // Registered state
  seq_t    state_nxt; // Next state
  logic    tick;      // Bus clock rising edge moment
  logic    atSample;  // Command minimum reached
  ready_if rdy ();    // Link to the ready sampler

  // Ready synchroniser, polarity and async stage
  ready_sampler u_sampler (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .readyPin (readyPin),
    .rdy      (rdy)
  );

  // Tick and sample window; ready matters only at window points
  always_comb begin
    tick     = (state_r.divCnt == DIV_LAST);
    atSample = (state_r.phase == PH_CMD) &&
               (state_r.cmdCnt >= state_r.cmdTicks);
    rdy.tick       = tick;
    rdy.sampleEn   = atSample && state_r.readyCtl;
    rdy.asyncMode  = state_r.async;
    rdy.activeHigh = state_r.actHigh;
  end

  // Next state of the sequencer
  always_comb begin
    state_nxt       = state_r;
    state_nxt.dMeta = dataIn;
    state_nxt.dSync = state_r.dMeta;
    state_nxt.done  = 1'b0;
    // Divider: high half then low half, rising edge on tick
    if (tick) begin
      state_nxt.divCnt = 4'h0;
      state_nxt.busClk = 1'b1;
    end else begin
      state_nxt.divCnt = state_r.divCnt + 4'h1;
      if (state_r.divCnt == DIV_HALF) begin
        state_nxt.busClk = 1'b0;
      end
    end
    if (tick) begin
      unique case (state_r.phase)
        // Take a request and drive address
        PH_IDLE: begin
          if (reqValid) begin
            state_nxt.phase    = PH_ADDR;
            state_nxt.idle     = 1'b0;
            state_nxt.write    = reqWrite;
            state_nxt.addr     = reqAddr;
            state_nxt.upperN   = ~reqUpper;
            state_nxt.wdata    = reqWdata;
            state_nxt.oe       = reqWrite;
            state_nxt.readyCtl = cfgReadyCtl;
            state_nxt.async    = cfgAsync;
            state_nxt.actHigh  = cfgActiveHigh;
            state_nxt.cmdTicks = cfgCmdTicks;
            state_nxt.waits    = WAIT_ZERO;
          end
        end
        // Assert the command strobe
        PH_ADDR: begin
          state_nxt.phase  = PH_CMD;
          state_nxt.cmdCnt = CNT_ONE;
          state_nxt.rdN    = state_r.write;
          state_nxt.wrN    = ~state_r.write;
        end
        // Command phase, then ready sample points
        PH_CMD: begin
          if (!atSample) begin
            state_nxt.cmdCnt = state_r.cmdCnt + CNT_ONE;
          end else if (!state_r.readyCtl || rdy.readyOk) begin
            state_nxt.phase = PH_END;
            state_nxt.rdN   = 1'b1;
            state_nxt.wrN   = 1'b1;
            state_nxt.addr  = ADDR_IDLE;
            if (!state_r.write) begin
              state_nxt.rdata = state_r.dSync;
            end
          end else begin
            state_nxt.waits = state_r.waits + WAIT_ONE;
          end
        end
        // Recovery: release data pins and report
        PH_END: begin
          state_nxt.phase  = PH_IDLE;
          state_nxt.oe     = 1'b0;
          state_nxt.upperN = 1'b1;
          state_nxt.done   = 1'b1;
          state_nxt.idle   = 1'b1;
        end
      endcase
    end
  end

  // State register; strobes and selects idle high
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r        <= '0;
      state_r.phase  <= PH_IDLE;
      state_r.rdN    <= 1'b1;
      state_r.wrN    <= 1'b1;
      state_r.upperN <= 1'b1;
      state_r.idle   <= 1'b1;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Outputs straight from the register
  assign reqReady          = state_r.idle;
  assign doneValid         = state_r.done;
  assign rdData            = state_r.rdata;
  assign waitCount         = state_r.waits;
  assign addrOut           = state_r.addr;
  assign rdStrobeN         = state_r.rdN;
  assign wrStrobeN         = state_r.wrN;
  assign upperByteSelectN  = state_r.upperN;
  assign dataOut           = state_r.wdata;
  assign dataOe            = state_r.oe;
  assign busReferenceClock = state_r.busClk;

  a_wait_holds: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tick && rdy.sampleEn && !rdy.readyOk |=>
      state_r.phase == PH_CMD && !(state_r.rdN && state_r.wrN))
    else $error("cycle ended without ready");

  a_ready_ends: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tick && rdy.sampleEn && rdy.readyOk |=>
      state_r.phase == PH_END && state_r.rdN && state_r.wrN)
    else $error("ready did not end the cycle");

  a_async_min_wait: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tick && rdy.sampleEn && state_r.async &&
      state_r.waits == WAIT_ZERO |=>
      state_r.waits == WAIT_ONE)
    else $error("async cycle without a wait state");

  a_wait_count: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tick && rdy.sampleEn && !rdy.readyOk |=>
      state_r.waits == $past(state_r.waits) + WAIT_ONE)
    else $error("wait count did not advance");

  a_read_capture: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(state_r.rdN) |->
      state_r.rdata == $past(state_r.dSync) && state_r.addr == ADDR_IDLE)
    else $error("read data not captured at strobe rise");

  a_ignore_ready: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tick && atSample && !state_r.readyCtl |=>
      state_r.phase == PH_END && state_r.waits == $past(state_r.waits))
    else $error("ready used in a cycle without ready control");

  c_async_wait: cover property (@(posedge ref_clk) disable iff (!rst_n)
    state_r.done && state_r.async && state_r.waits > WAIT_ONE);
  c_sync_read: cover property (@(posedge ref_clk) disable iff (!rst_n)
    state_r.done && !state_r.write && state_r.readyCtl && !state_r.async);
  c_plain_write: cover property (@(posedge ref_clk) disable iff (!rst_n)
    state_r.done && state_r.write && !state_r.readyCtl);

endmodule // ext_bus_ready_wait_control

// ==== verif/ready_partner.sv ====
`timescale 1ns/1ps
// Purpose: Model of the external memory that answers with ready
// Assumes: Ready and read data change just after the bus clock rises
// Notes:   Released lines show inverted values so stale data never passes
module ready_partner (
  input  wire logic        busClk,      // Bus reference clock
  input  wire logic        rdStrobeN,   // Read strobe
  input  wire logic        wrStrobeN,   // Write strobe
  input  wire logic [23:0] addrOut,     // Address pins
  input  wire logic [15:0] dataOut,     // Write data pins
  input  wire logic        activeHigh,  // Level that means ready
  input  wire logic        neverReady,  // Hold ready inactive
  input  wire logic [3:0]  delayTicks,  // Bus periods before ready
  output logic             readyPin,    // Ready answer
  output logic [15:0]      dataIn,      // Read data pins
  output logic [15:0]      wrSeen       // Last word written
);
  logic [3:0] cnt;  // Bus periods since the strobe fell

  initial begin
    cnt = 4'h0;
    readyPin = 1'b0;
    dataIn = 16'h0000;
    wrSeen = 16'h0000;
  end

  always @(posedge busClk) begin
    #2;
    // Ready stays active until the strobe rises, many periods long
    if (!rdStrobeN || !wrStrobeN) begin
      readyPin = (cnt >= delayTicks && !neverReady) ? activeHigh : ~activeHigh;
      if (cnt != 4'hf) cnt = cnt + 4'h1;
    end else begin
      readyPin = ~activeHigh;
      cnt = 4'h0;
    end
  end

  // read data garbled once strobe rises
  always @(posedge busClk) begin
    #2;
    dataIn = !rdStrobeN ? (addrOut[15:0] ^ 16'h5a5a) : ~dataIn;
    if (!wrStrobeN) wrSeen = dataOut;
  end
endmodule // ready_partner

// ==== verif/ext_bus_ready_wait_control_bench.sv ====
`timescale 1ns/1ps
// Purpose: Self-checking bench for ready-controlled bus cycles
// Assumes: Bus clock is one eighth of ref_clk
// Notes:   Cycle length is checked in system clocks from accept to done
module ext_bus_ready_wait_control_bench;
  import ext_bus_pkg::*;
  logic refClk = 1'b0;       // System clock
  logic rstN = 1'b0;         // Reset, low active
  logic reqValid = 1'b0;     // Request strobe
  logic reqWrite = 1'b0;     // Write when high
  logic [23:0] reqAddr = 24'h000000;
  logic [15:0] reqWdata = 16'h0000;
  logic reqUpper = 1'b0;     // Upper byte select request
  logic cfgReadyCtl = 1'b0;  // Cycle governed by ready
  logic cfgAsync = 1'b0;     // Extra sync stage
  logic cfgActiveHigh = 1'b1;
  logic [3:0] cfgCmdTicks = 4'h1;
  logic neverReady = 1'b1;   // Partner never answers
  logic [3:0] delayTicks = 4'h0;
  logic readyPin, reqReady, doneValid, rdStrobeN, wrStrobeN;
  logic upperByteSelectN, dataOe, busReferenceClock;
  logic [15:0] dataIn, rdData, dataOut, wrSeen;
  logic [7:0] waitCount;
  logic [23:0] addrOut;
  int errorCnt = 0;          // Mismatches
  int cmpCount = 0;          // Comparisons

  // Clock at 40 MHz
  always #12.5 refClk = ~refClk;

  ext_bus_ready_wait_control dut_u (.ref_clk(refClk), .rst_n(rstN),
    .reqValid(reqValid), .reqWrite(reqWrite), .reqAddr(reqAddr),
    .reqWdata(reqWdata), .reqUpper(reqUpper), .cfgReadyCtl(cfgReadyCtl),
    .cfgAsync(cfgAsync), .cfgActiveHigh(cfgActiveHigh),
    .cfgCmdTicks(cfgCmdTicks), .readyPin(readyPin), .dataIn(dataIn),
    .reqReady(reqReady), .doneValid(doneValid), .rdData(rdData),
    .waitCount(waitCount), .addrOut(addrOut), .rdStrobeN(rdStrobeN),
    .wrStrobeN(wrStrobeN), .upperByteSelectN(upperByteSelectN),
    .dataOut(dataOut), .dataOe(dataOe),
    .busReferenceClock(busReferenceClock));

  ready_partner mem_u (.busClk(busReferenceClock), .rdStrobeN(rdStrobeN),
    .wrStrobeN(wrStrobeN), .addrOut(addrOut), .dataOut(dataOut),
    .activeHigh(cfgActiveHigh), .neverReady(neverReady),
    .delayTicks(delayTicks), .readyPin(readyPin), .dataIn(dataIn),
    .wrSeen(wrSeen));

  // Ends the run with the verdict
  task automatic giveVerdict();
    if (errorCnt == 0 && cmpCount > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      errorCnt++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // Wait states from command length, ready delay and mode
  function automatic int expWaits(int c, int d, bit async, bit ctl);
    int ce;
    ce = (c == 0) ? 1 : c;
    if (!ctl) return 0;
    if (async) return (d + 2 - ce > 1) ? d + 2 - ce : 1;
    return (d + 1 - ce > 0) ? d + 1 - ce : 0;
  endfunction

  // One bus cycle; all drives land 1 ns after a rising edge
  task automatic runCycle(input logic wr, ctl, async, hi,
                          input logic [3:0] c, d);
    int n;
    int w;
    int ce;
    w = expWaits(c, d, async, ctl);
    ce = (c == 4'h0) ? 1 : int'(c);
    reqWrite = wr;
    reqAddr = 24'($urandom);
    reqWdata = 16'($urandom);
    reqUpper = 1'($urandom);
    cfgReadyCtl = ctl;
    cfgAsync = async;
    cfgActiveHigh = hi;
    cfgCmdTicks = c;
    neverReady = !ctl;
    delayTicks = d;
    reqValid = 1'b1;
    n = 0;
    do begin
      @(posedge refClk);
      #1;
      n++;
    end while (reqReady !== 1'b0 && n < 40);
    reqValid = 1'b0;
    check("address", {8'h00, addrOut}, {8'h00, reqAddr});
    check("upper select", upperByteSelectN, {31'h0, ~reqUpper});
    check("data drive", dataOe, wr);
    check("bus clock rise", busReferenceClock, 1'b1);
    n = 1;
    while (doneValid !== 1'b1 && n < 400) begin
      @(posedge refClk);
      #1;
      n++;
      // Strobe falls one bus period after accept
      if (n == 9) check("strobe", {rdStrobeN, wrStrobeN}, {wr, !wr});
    end
    n--;
    // Accept, strobe tick, ce command ticks, w waits, then done tick
    check("cycle length", n, (ce + 2 + w) * 8);
    check("idle pins", {addrOut, rdStrobeN, wrStrobeN, upperByteSelectN,
                        dataOe}, {24'h000000, 4'he});
    check("bus clock done", busReferenceClock, 1'b1);
    check("wait count", waitCount, w);
    if (!wr) check("read data", rdData, reqAddr[15:0] ^ 16'h5a5a);
    else check("write data", wrSeen, reqWdata);
    @(posedge refClk);
    #1;
    check("done pulse", doneValid, 1'b0);
  endtask

  // Main sequence: corners first, then random cycles
  initial begin
    void'($urandom(68896));
    repeat (4) @(posedge refClk);
    #1;
    check("reset idle", {reqReady, rdStrobeN, wrStrobeN, upperByteSelectN,
                         dataOe, doneValid, busReferenceClock},
          7'b1111000);
    check("reset address", addrOut, 24'h000000);
    rstN = 1'b1;
    for (int m = 0; m < 4; m++) begin
      runCycle(1'b0, 1'b1, m[0], m[1], 4'h1, 4'h0);
      runCycle(1'b1, 1'b1, m[0], m[1], 4'h3, 4'h0);
      runCycle(1'b0, 1'b1, m[0], m[1], 4'h0, 4'h5);
    end
    runCycle(1'b0, 1'b0, 1'b0, 1'b0, 4'h2, 4'h0);
    for (int i = 0; i < 40; i++) begin
      runCycle(1'($urandom), 1'($urandom), 1'($urandom), 1'($urandom),
               4'($urandom_range(0, 3)), 4'($urandom_range(0, 5)));
    end
    giveVerdict();
  end

  // Watchdog well beyond the expected run
  initial begin
    #(25 * 60000);
    errorCnt++;
    giveVerdict();
  end
endmodule // ext_bus_ready_wait_control_bench
